// *** rtl/epm_pkg.sv ***
// constants, field positions and modes shared by the ethernet pin mux files
// assumes one system clock; every board-side input is asynchronous to it
package epm_pkg;

  // ----------------------------------------------------------------
  // attachment modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_INT_SERDES,
    MODE_EXT_SERDES,
    MODE_MII,
    MODE_GMII
  } epm_mode_e;

  localparam epm_mode_e MODE_RST = MODE_INT_SERDES;

  // ----------------------------------------------------------------
  // transmit word layout: bit 9 goes out first in ten-bit mode
  // ----------------------------------------------------------------
  localparam int TX_W        = 10;
  localparam int TXB_TOP     = 9;
  localparam int TXB_SECOND  = 8;
  localparam int TXB_UP_HI   = 7;
  localparam int TXB_UP_LO   = 4;
  localparam int TXB_LO_HI   = 3;
  localparam int FIFO_DEPTH  = 8;
  localparam logic [TX_W-1:0] TX_IDLE = 10'h000;

  // ----------------------------------------------------------------
  // synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int SI_TXREF = 0;
  localparam int SI_RXA   = 1;
  localparam int SI_RXB   = 2;
  localparam int SI_LSD   = 3;
  localparam int SI_COL   = 4;
  localparam int SI_CRS   = 5;
  localparam int SI_MDIO  = 6;
  localparam int SI_RX_LO = 7;
  localparam int SI_RX_HI = 16;
  localparam int SYNC_W   = 17;

  // ----------------------------------------------------------------
  // local clock divider and reset values
  // ----------------------------------------------------------------
  localparam int LCLK_DIV = 4;
  localparam int DIV_W    = $clog2(LCLK_DIV);
  localparam logic MGMT_CLK_RST = 1'h0;
  localparam logic MGMT_OE_RST  = 1'h0;

endpackage

// *** rtl/epm_stream_if.sv ***
// valid/ready word stream between the pin mux and its transmit fifo
// assumes both ends run on the same clock
interface epm_stream_if #(parameter int W = 10) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** rtl/epm_sync.sv ***
// two-flop synchroniser for a bundle of asynchronous levels
// assumes the inputs are quasi-static relative to the clock
module epm_sync #(
  parameter int W = 1
) (
  // clock, reset, enable
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// *** rtl/epm_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
// assumes a single clock; depth is a power of two
module epm_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 8
) (
  // clock, reset, enable
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  ce,
  // streams
  epm_stream_if.snk  wr,
  epm_stream_if.src  rd
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0]   count;
  logic [AW:0]   next_count;

  wire doWr = wr.valid && wr.ready && ce;
  wire doRd = rd.valid && rd.ready && ce;

  assign wr.ready   = (count != FULL_CNT);
  assign rd.valid   = (count != '0);
  assign rd.data    = mem[rdPtr];
  assign next_count = doWr && !doRd ? count + 1'b1 :
                      !doWr && doRd ? count - 1'b1 : count;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWr) wrPtr <= wrPtr + 1'b1;
      if (doRd) rdPtr <= rdPtr + 1'b1;
      count <= next_count;
    end
  end

  always_ff @(posedge clk) begin
    if (doWr) mem[wrPtr] <= wr.data;
  end

endmodule

// *** rtl/epm_phy_if_mux.sv ***
// ethernet physical attachment pin mux: one mode steers all shared pins and clocks
// assumes board clocks and pins are asynchronous and sampled on mclk
module epm_phy_if_mux (
  // clock, reset, enable
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire logic                    ce,
  // configuration
  input  wire logic                    modeLoad,
  input  wire epm_pkg::epm_mode_e      modeVal,
  output epm_pkg::epm_mode_e           phy_clock_mode_sel,
  input  wire logic                    txClkOutEn,
  // mac transmit stream
  input  wire logic                    txValid,
  output logic                         txReady,
  input  wire logic [epm_pkg::TX_W-1:0] txData,
  // internal serializer side
  output logic                         serdesRefTick,
  output logic [epm_pkg::TX_W-1:0]     serdesTxWord,
  output logic                         serdesTxStrobe,
  // board clocks
  input  wire logic                    tx_ref_clk_in,
  input  wire logic                    rx_clk_a,
  input  wire logic                    rx_clk_b_or_mii_tx_clk,
  output logic                         tx_clk_out,
  output logic                         tx_clk_out_oe,
  // transmit pins
  output logic                         tx_bit9_or_tx_err,
  output logic                         tx_bit8_or_tx_en,
  output logic [3:0]                   tx_bits_upper,
  output logic [3:0]                   tx_bits_lower,
  output logic                         txCtlOe,
  output logic                         txUpperOe,
  output logic                         txLowerOe,
  // receive pins
  input  wire logic                    rx_bit9_or_rx_err,
  input  wire logic                    rx_bit8_or_rx_dv,
  input  wire logic [2:0]              rx_bits_upper,
  input  wire logic                    rx_bit4_or_link_in,
  input  wire logic [3:0]              rx_bits_lower,
  input  wire logic                    line_signal_detect_in,
  input  wire logic                    phyCol,
  input  wire logic                    phyCrs,
  // mac receive side
  output logic [epm_pkg::TX_W-1:0]     rxWord,
  output logic                         rxWordValid,
  output logic                         rxErr,
  output logic                         rxDv,
  output logic                         linkUp,
  output logic                         collision,
  output logic                         carrier,
  // management pins and requests
  input  wire logic                    mgmtClkReq,
  input  wire logic                    mgmtDatOut,
  input  wire logic                    mgmtDatOe,
  output logic                         mgmtDatIn,
  output logic                         phyMgmtClk,
  output logic                         phyMgmtDatO,
  output logic                         phyMgmtDatOe,
  input  wire logic                    phyMgmtDatI
);
  import epm_pkg::*;

  // ----------------------------------------------------------------
  // mode setting
  // ----------------------------------------------------------------
  epm_mode_e modeSel;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      modeSel <= MODE_RST;
    end else if (ce && modeLoad) begin
      modeSel <= modeVal;
    end
  end

  wire modeInt     = (modeSel == MODE_INT_SERDES);
  wire modeExt     = (modeSel == MODE_EXT_SERDES);
  wire modeMii     = (modeSel == MODE_MII);
  wire modeGmii    = (modeSel == MODE_GMII);
  wire modeExtGmii = modeExt || modeGmii;
  wire modePins    = !modeInt;
  wire modeColCrs  = modeGmii || modeMii;

  assign phy_clock_mode_sel = modeSel;

  // ----------------------------------------------------------------
  // input synchronisation and clock edges
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] syncIn;
  logic [SYNC_W-1:0] syncQ;
  logic              refPrev;
  logic              rxAPrev;
  logic              rxBPrev;

  assign syncIn = {rx_bit9_or_rx_err, rx_bit8_or_rx_dv, rx_bits_upper, rx_bit4_or_link_in,
                   rx_bits_lower, phyMgmtDatI, phyCrs, phyCol, line_signal_detect_in,
                   rx_clk_b_or_mii_tx_clk, rx_clk_a, tx_ref_clk_in};

  epm_sync #(.W(SYNC_W)) u_sync (
    .clk (mclk),
    .rst (sys_rst),
    .ce  (ce),
    .d   (syncIn),
    .q   (syncQ)
  );

  // the board runs these clocks also through reset; the reference and secondary clocks may stop
  wire refS = syncQ[SI_TXREF];
  wire rxAS = syncQ[SI_RXA];
  wire rxBS = syncQ[SI_RXB];
  wire lsdS = syncQ[SI_LSD];
  wire colS = syncQ[SI_COL];
  wire crsS = syncQ[SI_CRS];
  wire [TX_W-1:0] rxPins = syncQ[SI_RX_HI:SI_RX_LO];

  wire refRise = refS && !refPrev;
  wire rxARise = rxAS && !rxAPrev;
  wire rxBRise = rxBS && !rxBPrev;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      refPrev <= 1'h0;
      rxAPrev <= 1'h0;
      rxBPrev <= 1'h0;
    end else if (ce) begin
      refPrev <= refS;
      rxAPrev <= rxAS;
      rxBPrev <= rxBS;
    end
  end

  // ----------------------------------------------------------------
  // transmit clocks
  // ----------------------------------------------------------------
  logic             halfPh;
  logic [DIV_W-1:0] divCnt;
  logic             txClkReg;

  // a fast reference only reaches the serializer on every other edge
  assign serdesRefTick = refRise && (modeExtGmii ? halfPh : 1'b1);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      halfPh   <= 1'h0;
      divCnt   <= '0;
      txClkReg <= 1'h0;
    end else if (ce) begin
      if (refRise) halfPh <= !halfPh;
      divCnt   <= divCnt + 1'b1;
      txClkReg <= modeExtGmii ? !refS : divCnt[DIV_W-1];
    end
  end

  assign tx_clk_out    = txClkReg;
  assign tx_clk_out_oe = txClkOutEn;

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  epm_stream_if #(.W(TX_W)) macTx ();
  epm_stream_if #(.W(TX_W)) pinTx ();

  // symbol rate: reference in gmii/ten-bit, secondary pin in mii
  wire popTick = modeExtGmii ? refRise :
                 modeMii     ? rxBRise : serdesRefTick;

  assign macTx.valid = txValid;
  assign macTx.data  = txData;
  assign txReady     = macTx.ready;
  assign pinTx.ready = popTick;

  epm_fifo #(.W(TX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk (mclk),
    .rst (sys_rst),
    .ce  (ce),
    .wr  (macTx),
    .rd  (pinTx)
  );

  logic [TX_W-1:0] txWord;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      txWord         <= TX_IDLE;
      serdesTxStrobe <= 1'h0;
    end else if (ce) begin
      serdesTxStrobe <= popTick && modeInt && pinTx.valid;
      if (popTick) txWord <= pinTx.valid ? pinTx.data : TX_IDLE;
    end
  end

  // word bit 9 is the first bit on the wire; any reversal is the board's
  assign tx_bit9_or_tx_err = txWord[TXB_TOP];
  assign tx_bit8_or_tx_en  = txWord[TXB_SECOND];
  assign tx_bits_upper     = txWord[TXB_UP_HI:TXB_UP_LO];
  assign tx_bits_lower     = txWord[TXB_LO_HI:0];
  assign txCtlOe           = modePins;
  assign txUpperOe         = modeExtGmii;
  assign txLowerOe         = modePins;
  assign serdesTxWord      = txWord;

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  logic miiLink;

  wire rxTick = modeExt  ? (rxARise || rxBRise) :
                modePins ? rxARise : 1'b0;
  wire [TX_W-1:0] rxGmiiWord = {2'h0, rxPins[TXB_UP_HI:0]};
  wire [TX_W-1:0] rxMiiWord  = {6'h00, rxPins[TXB_LO_HI:0]};
  wire [TX_W-1:0] next_rxWord = modeExt  ? rxPins :
                                modeGmii ? rxGmiiWord : rxMiiWord;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rxWord      <= '0;
      rxWordValid <= 1'h0;
      rxErr       <= 1'h0;
      rxDv        <= 1'h0;
      miiLink     <= 1'h0;
      linkUp      <= 1'h0;
      collision   <= 1'h0;
      carrier     <= 1'h0;
    end else if (ce) begin
      rxWordValid <= rxTick;
      if (rxTick) begin
        rxWord <= next_rxWord;
        rxErr  <= !modeExt && rxPins[TXB_TOP];
        rxDv   <= !modeExt && rxPins[TXB_SECOND];
        if (modeMii) miiLink <= rxPins[TXB_UP_LO];
      end
      linkUp    <= modeMii ? miiLink : lsdS;
      collision <= modeColCrs && colS;
      carrier   <= modeColCrs && crsS;
    end
  end

  // ----------------------------------------------------------------
  // management pins
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      phyMgmtClk   <= MGMT_CLK_RST;
      phyMgmtDatO  <= 1'h0;
      phyMgmtDatOe <= MGMT_OE_RST;
      mgmtDatIn    <= 1'h0;
    end else if (ce) begin
      phyMgmtClk   <= mgmtClkReq;
      phyMgmtDatO  <= mgmtDatOut;
      phyMgmtDatOe <= mgmtDatOe;
      mgmtDatIn    <= syncQ[SI_MDIO];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_pop;
    ce && popTick && pinTx.valid && modePins;
  endsequence

  sequence s_div_run;
    (ce && !modeExtGmii)[*3];
  endsequence

  property p_txclk_inv;
    @(posedge mclk) disable iff (sys_rst)
    (ce && modeExtGmii) |=> (tx_clk_out == !$past(refS));
  endproperty
  a_txclk_inv: assert property (p_txclk_inv) else $error("tx clock not inverted ref");

  property p_txclk_div;
    @(posedge mclk) disable iff (sys_rst)
    s_div_run |=> (tx_clk_out != $past(tx_clk_out, 2));
  endproperty
  a_txclk_div: assert property (p_txclk_div) else $error("tx clock not local/4");

  property p_ref_half;
    @(posedge mclk) disable iff (sys_rst)
    (ce && modeExtGmii && serdesRefTick) |=> (!serdesRefTick)[*2];
  endproperty
  a_ref_half: assert property (p_ref_half) else $error("serializer ref not halved");

  property p_tx_pins;
    @(posedge mclk) disable iff (sys_rst)
    s_pop |=> ({tx_bit9_or_tx_err, tx_bit8_or_tx_en, tx_bits_upper, tx_bits_lower}
               == $past(pinTx.data));
  endproperty
  a_tx_pins: assert property (p_tx_pins) else $error("tx pins not popped word");

  property p_tx_idle;
    @(posedge mclk) disable iff (sys_rst)
    (ce && popTick && !pinTx.valid) |=> !tx_bit8_or_tx_en;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("tx enable set with no data");

  property p_mii_oe;
    @(posedge mclk) disable iff (sys_rst)
    modeMii |-> (!txUpperOe && txLowerOe && txCtlOe);
  endproperty
  a_mii_oe: assert property (p_mii_oe) else $error("mii drives upper tx bits");

  property p_gmii_rx;
    @(posedge mclk) disable iff (sys_rst)
    (ce && rxTick && modeGmii) |=>
      (rxErr == $past(rxPins[TXB_TOP]) && rxDv == $past(rxPins[TXB_SECOND]));
  endproperty
  a_gmii_rx: assert property (p_gmii_rx) else $error("gmii rx err/dv wrong");

  property p_mii_link;
    @(posedge mclk) disable iff (sys_rst)
    (ce && rxTick && modeMii) |=>
      (miiLink == $past(rxPins[TXB_UP_LO]) && rxWord[TX_W-1:TXB_UP_LO] == '0);
  endproperty
  a_mii_link: assert property (p_mii_link) else $error("mii link bit wrong");

  property p_rx_lower;
    @(posedge mclk) disable iff (sys_rst)
    (ce && rxTick) |=> (rxWordValid && rxWord[TXB_LO_HI:0] == $past(rxPins[TXB_LO_HI:0]));
  endproperty
  a_rx_lower: assert property (p_rx_lower) else $error("rx low bits wrong");

  property p_ext_rxb;
    @(posedge mclk) disable iff (sys_rst)
    (ce && modeExt && rxBRise) |=> rxWordValid;
  endproperty
  a_ext_rxb: assert property (p_ext_rxb) else $error("second rx clock ignored");

  property p_colcrs;
    @(posedge mclk) disable iff (sys_rst)
    (ce && !modeColCrs) |=> (!collision && !carrier);
  endproperty
  a_colcrs: assert property (p_colcrs) else $error("col/crs used outside mii/gmii");

  property p_mgmt_rst;
    @(posedge mclk) sys_rst |=> (!phyMgmtClk && !phyMgmtDatOe);
  endproperty
  a_mgmt_rst: assert property (p_mgmt_rst) else $error("mgmt pins active in reset");

  property p_mode_load;
    @(posedge mclk) disable iff (sys_rst)
    (ce && modeLoad) |=> (phy_clock_mode_sel == $past(modeVal));
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode not loaded");

endmodule

// *** verification/epm_phy_model.sv ***
// far-side model: board clocks, receive pins and capture of transmit pins
// assumes the bench sets mode, receive value and clock run controls
module epm_phy_model (
  // bench controls
  input  wire logic               refRun,
  input  wire logic               bRun,
  input  wire epm_pkg::epm_mode_e boardMode,
  input  wire logic [9:0]         rxVal,
  // board clocks and receive pins
  output logic                    tx_ref_clk_in,
  output logic                    rx_clk_a,
  output logic                    rx_clk_b_or_mii_tx_clk,
  output logic [9:0]              rxPins,
  // transmit pins and what was seen on them
  input  wire logic [9:0]         txPins,
  output logic [9:0]              capWord,
  output int                      capCount
);
  timeunit 1ns;
  timeprecision 1ps;
  import epm_pkg::*;

  logic [9:0] seen;

  // upper transmit pins are not used in mii
  assign seen = boardMode == MODE_MII ? {txPins[9:8], 4'h0, txPins[3:0]} : txPins;

  // ----------------------------------------------------------------
  // clocks run also during reset, unrelated to mclk; reference and secondary only while refRun/bRun are high
  // ----------------------------------------------------------------
  initial begin
    tx_ref_clk_in = 1'b0;
    forever #41 if (refRun) tx_ref_clk_in = ~tx_ref_clk_in;
  end
  initial begin
    rx_clk_a = 1'b0;
    forever #48 rx_clk_a = ~rx_clk_a;
  end
  initial begin
    rx_clk_b_or_mii_tx_clk = 1'b0;
    forever #56 if (bRun) rx_clk_b_or_mii_tx_clk = ~rx_clk_b_or_mii_tx_clk;
  end

  // ----------------------------------------------------------------
  // receive launch and transmit capture
  // ----------------------------------------------------------------
  logic refLast = 1'b0;
  logic bLast   = 1'b0;

  always @(negedge rx_clk_a) rxPins <= rxVal;
  // bit 9 is the first bit on the wire; no reversal on this side
  // one process owns the capture: mii on the secondary clock, ten-bit and gmii on the reference, none in internal serdes
  always @(tx_ref_clk_in or rx_clk_b_or_mii_tx_clk) begin
    if (boardMode == MODE_MII ? rx_clk_b_or_mii_tx_clk && !bLast :
        boardMode != MODE_INT_SERDES && tx_ref_clk_in && !refLast) grab();
    refLast = tx_ref_clk_in;
    bLast   = rx_clk_b_or_mii_tx_clk;
  end

  task automatic grab();
    if (seen !== 10'h000) begin
      capWord = seen;
      capCount++;
    end
  endtask
endmodule

// *** verification/epm_phy_if_mux_tb.sv ***
// self-checking bench for the ethernet pin mux
// assumes epm_phy_model on the far side and a 125 MHz mclk
module epm_phy_if_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import epm_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct {
    epm_mode_e  m;
    logic [2:0] oe;
    logic [9:0] rxW;
    logic [4:0] flg;
    logic [9:0] txPin;
    int         clkExp;
    int         tickExp;
  } epm_row_s;
  epm_row_s        rows [4];
  epm_mode_e       modeVal, phy_clock_mode_sel;
  logic [TX_W-1:0] txData, serdesTxWord, rxWord, capWord;
  logic [9:0]      rxVal, rxPins;
  logic [3:0]      tx_bits_upper, tx_bits_lower;
  logic            mclk, sys_rst, ce, modeLoad, txClkOutEn, txValid, txReady, serdesRefTick;
  logic            serdesTxStrobe, tx_ref_clk_in, rx_clk_a, rx_clk_b_or_mii_tx_clk, tx_clk_out;
  logic            tx_clk_out_oe, tx_bit9_or_tx_err, tx_bit8_or_tx_en, txCtlOe, txUpperOe;
  logic            txLowerOe, lsd, col, crs, rxWordValid, rxErr, rxDv, linkUp, collision;
  logic            carrier, mgmtClkReq, mgmtDatOut, mgmtDatOe, mgmtDatIn, phyMgmtClk;
  logic            phyMgmtDatO, phyMgmtDatOe, phyMgmtDatI, mdPhyEn, mdPhyVal, refRun, bRun;
  int              mismatches, testsRun, capCount, n0, rises, ticks, i;

  // released management line falls to its pull-down
  assign phyMgmtDatI = phyMgmtDatOe ? phyMgmtDatO : (mdPhyEn ? mdPhyVal : 1'b0);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  epm_phy_model phy (.refRun, .bRun, .boardMode(phy_clock_mode_sel), .rxVal, .tx_ref_clk_in,
    .rx_clk_a, .rx_clk_b_or_mii_tx_clk, .rxPins, .capWord, .capCount,
    .txPins({tx_bit9_or_tx_err, tx_bit8_or_tx_en, tx_bits_upper, tx_bits_lower}));

  epm_phy_if_mux uut (.mclk, .sys_rst, .ce, .modeLoad, .modeVal, .phy_clock_mode_sel,
    .txClkOutEn, .txValid, .txReady, .txData, .serdesRefTick, .serdesTxWord, .serdesTxStrobe,
    .tx_ref_clk_in, .rx_clk_a, .rx_clk_b_or_mii_tx_clk, .tx_clk_out, .tx_clk_out_oe,
    .tx_bit9_or_tx_err, .tx_bit8_or_tx_en, .tx_bits_upper, .tx_bits_lower, .txCtlOe,
    .txUpperOe, .txLowerOe, .rx_bit9_or_rx_err(rxPins[9]), .rx_bit8_or_rx_dv(rxPins[8]),
    .rx_bits_upper(rxPins[7:5]), .rx_bit4_or_link_in(rxPins[4]), .rx_bits_lower(rxPins[3:0]),
    .line_signal_detect_in(lsd), .phyCol(col), .phyCrs(crs), .rxWord, .rxWordValid, .rxErr,
    .rxDv, .linkUp, .collision, .carrier, .mgmtClkReq, .mgmtDatOut, .mgmtDatOe, .mgmtDatIn,
    .phyMgmtClk, .phyMgmtDatO, .phyMgmtDatOe, .phyMgmtDatI);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  task automatic cmpV(logic [15:0] got, logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmpN(int got, int exp, int tol);
    testsRun++;
    if (got < exp - tol || got > exp + tol) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic endOfTest();
    if (mismatches == 0 && testsRun > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic timeout();
    cmpN(0, 1, 0);
    endOfTest();
  endtask

  task automatic loadMode(epm_mode_e v);
    modeLoad = 1'b1;
    modeVal = v;
    tick();
    modeLoad = 1'b0;
  endtask

  task automatic pushWord(logic [TX_W-1:0] d);
    txValid = 1'b1;
    txData = d;
    tick();
    txValid = 1'b0;
  endtask

  task automatic waitRx();
    int k;
    for (k = 0; k < 60 && rxWordValid !== 1'b1; k++) tick();
    if (k == 60) timeout();
    tick();
  endtask

  task automatic waitCap(int n);
    int k;
    for (k = 0; k < 80 && capCount == n; k++) tick();
    if (k == 80) timeout();
  endtask

  // counts tx_clk_out rises and reference ticks over 32 reference periods
  task automatic measure(output int r, output int t);
    logic prev;
    r = 0;
    t = 0;
    prev = tx_clk_out;
    repeat (328) begin
      tick();
      if (tx_clk_out === 1'b1 && prev === 1'b0) r++;
      if (serdesRefTick === 1'b1) t++;
      prev = tx_clk_out;
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {sys_rst, ce, refRun, bRun, col, crs} = 6'h3f;
    {modeLoad, txClkOutEn, txValid, mgmtClkReq, mgmtDatOut, mgmtDatOe, mdPhyEn, mdPhyVal} = 8'h00;
    lsd = 1'b0;
    modeVal = MODE_INT_SERDES;
    txData = 10'h000;
    rxVal = 10'h3b5;
    rows = '{'{MODE_INT_SERDES, 3'h0, 10'h000, 5'h00, 10'h000, 82, 32},
             '{MODE_EXT_SERDES, 3'h7, 10'h3b5, 5'h00, 10'h3c6, 32, 16},
             '{MODE_MII,        3'h5, 10'h005, 5'h1d, 10'h306, 82, 32},
             '{MODE_GMII,       3'h7, 10'h0b5, 5'h1e, 10'h3c6, 32, 16}};
    repeat (16) tick();
    sys_rst = 1'b0;
    tick();
    cmpV({phyMgmtClk, phyMgmtDatOe, mgmtDatIn, txReady}, 4'h1);
    foreach (rows[r]) begin
      // signal detect only in gmii, col and crs each low in one pin mode
      {lsd, col, crs} = {r == 3, r != 2, r != 3};
      loadMode(rows[r].m);
      cmpV(phy_clock_mode_sel, rows[r].m);
      cmpV({txCtlOe, txUpperOe, txLowerOe}, rows[r].oe);
      if (rows[r].m == MODE_INT_SERDES) begin
        n0 = 0;
        repeat (60) begin
          tick();
          if (rxWordValid !== 1'b0) n0++;
        end
        cmpN(n0, 0, 0);
      end else begin
        waitRx();
        waitRx();
      end
      cmpV(rxWord, rows[r].rxW);
      cmpV({rxErr, rxDv, linkUp, collision, carrier}, rows[r].flg);
      if (rows[r].m != MODE_INT_SERDES) begin
        n0 = capCount;
        pushWord(10'h3c6);
        waitCap(n0);
        cmpV(capWord, rows[r].txPin);
      end
      measure(rises, ticks);
      cmpN(rises, rows[r].clkExp, 1);
      cmpN(ticks, rows[r].tickExp, 1);
    end
    // mii transmit waits for the secondary clock
    loadMode(MODE_MII);
    bRun = 1'b0;
    repeat (20) tick();
    n0 = capCount;
    pushWord(10'h2c9);
    repeat (40) tick();
    cmpN(capCount, n0, 0);
    bRun = 1'b1;
    waitCap(n0);
    cmpV(capWord, 10'h209);
    // fifo fills while the reference is stopped, then drains in order
    loadMode(MODE_INT_SERDES);
    refRun = 1'b0;
    repeat (10) tick();
    txValid = 1'b1;
    for (i = 0; i < 10 && txReady === 1'b1; i++) begin
      txData = 10'(i + 1);
      tick();
    end
    txValid = 1'b0;
    cmpN(i, FIFO_DEPTH, 0);
    cmpV(txReady, 1'b0);
    refRun = 1'b1;
    for (int w = 1; w <= FIFO_DEPTH; w++) begin
      for (i = 0; i < 60 && serdesTxStrobe !== 1'b1; i++) tick();
      if (i == 60) timeout();
      cmpV(serdesTxWord, 16'(w));
      tick();
    end
    cmpV(txReady, 1'b1);
    // mode load ignored while frozen
    ce = 1'b0;
    loadMode(MODE_GMII);
    ce = 1'b1;
    cmpV(phy_clock_mode_sel, MODE_INT_SERDES);
    txClkOutEn = 1'b1;
    tick();
    cmpV(tx_clk_out_oe, 1'b1);
    txClkOutEn = 1'b0;
    tick();
    cmpV(tx_clk_out_oe, 1'b0);
    // management pass-through and pull-down
    {mgmtClkReq, mgmtDatOe, mgmtDatOut} = 3'h7;
    tick();
    cmpV({phyMgmtClk, phyMgmtDatOe, phyMgmtDatO}, 3'h7);
    {mgmtDatOe, mdPhyEn, mdPhyVal} = 3'h3;
    repeat (5) tick();
    cmpV(mgmtDatIn, 1'b1);
    mdPhyEn = 1'b0;
    repeat (5) tick();
    cmpV(mgmtDatIn, 1'b0);
    // second reset in mid-run with the management clock request still raised
    loadMode(MODE_GMII);
    sys_rst = 1'b1;
    tick();
    cmpV({phyMgmtClk, phyMgmtDatOe, phy_clock_mode_sel, txCtlOe}, 5'h00);
    sys_rst = 1'b0;
    mgmtClkReq = 1'b0;
    tick();
    endOfTest();
  end
endmodule
